// *** common/fault_log_pkg.sv ***
// Constants for the fault-log preamble formatter.
// Assumes a 250 MHz core clock and an AXI4-Lite register slave.
package fault_log_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TS_TICK_NS = 200000;
  localparam int TS_TICK_CYCLES = TS_TICK_NS * CLK_MHZ / 1000;
  localparam int TS_BITS = 41;
  // ---------------------------------------------------------------
  // Record layout
  // ---------------------------------------------------------------
  localparam int B_PTR = 0;
  localparam int B_VCNT = 1;
  localparam int B_TS = 2;
  localparam int B_TS_TOP = 7;
  localparam int B_CH01 = 8;
  localparam int B_VIN = 16;
  localparam int B_CH23 = 20;
  localparam int B_TEMP = 28;
  localparam int B_CH47 = 32;
  localparam int B_STAT = 48;
  localparam int B_PRE_END = 71;
  localparam int PRE_BYTES = 72;
  localparam int REC_END = 237;
  localparam int LOOP_BYTES = 46;
  localparam logic [7:0] BLK_COUNT = 8'hFF;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_INT_STAT = 8'h08;
  localparam logic [7:0] A_INT_CLR = 8'h0C;
  localparam logic [7:0] A_INT_EN = 8'h10;
  localparam logic [7:0] A_TS_LO = 8'h14;
  localparam logic [7:0] A_TS_HI = 8'h18;
  localparam logic CTRL_RST = 1'h1;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam int EV_CAPTURE = 0;
  localparam int EV_DONE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/fault_log_preamble_formatter.sv ***
// Fault-log record formatter: snapshot, byte stream, register slave.
// Assumes fault_event, read_start and the stream handshake come from
// logic on aclk; cyc_byte answers cyc_pos in the same cycle.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Operation
// - Byte 0 holds the cyclic log pointer as it stood at the fault.
// - Byte 1 holds the eight-bit count of valid cyclic bytes.
// - Bytes 2 to 7 hold the 41-bit timestamp, low byte first, bit 40 alone.
// - The timestamp advances by one every 200 us.
// - Each quantity gives peak then minimum, 16 bits low byte first.
// - Input supply extremes sit at bytes 16 to 19.
// - Die temperature extremes sit at bytes 28 to 31, channels 4-7 after.
// - From byte 48, three status bytes per channel, channels 0 to 7.
// - The preamble ends at byte 71 and cyclic data follows it.
// - Cyclic data starts at the stored pointer and counts down mod 46.
// - The block read opens with count 0xFF, then the pointer byte.
module fault_log_preamble_formatter #(
  parameter int TICK_CYCLES = fault_log_pkg::TS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // Fault snapshot sources
  input wire logic fault_event,
  input wire logic [7:0] log_pointer,
  input wire logic [7:0] valid_count,
  input wire logic [7:0][15:0] vout_peak,
  input wire logic [7:0][15:0] vout_min,
  input wire logic [15:0] vin_peak,
  input wire logic [15:0] vin_min,
  input wire logic [15:0] temp_peak,
  input wire logic [15:0] temp_min,
  input wire logic [7:0][7:0] vout_status,
  input wire logic [7:0][7:0] vendor_status,
  input wire logic [7:0][7:0] vendor_status2,
  // Record byte stream
  input wire logic read_start,
  output logic rec_valid,
  output logic [7:0] rec_data,
  output logic rec_last,
  input wire logic rec_ready,
  output logic [7:0] cyc_pos,
  input wire logic [7:0] cyc_byte
);
  typedef enum logic [1:0] {S_IDLE, S_PRE, S_CYC, S_LAST} st_e;

  function automatic int ext_base(input int c);
    if (c < 2) begin
      return fault_log_pkg::B_CH01 + 4 * c;
    end else if (c < 4) begin
      return fault_log_pkg::B_CH23 + 4 * (c - 2);
    end
    return fault_log_pkg::B_CH47 + 4 * (c - 4);
  endfunction

  // ---------------------------------------------------------------
  // Timestamp
  // ---------------------------------------------------------------
  logic [31:0] presc, next_presc;
  logic [40:0] ts, next_ts;

  always_comb begin
    next_presc = presc + 32'h00000001;
    next_ts = ts;
    if (presc == 32'(TICK_CYCLES - 1)) begin
      next_presc = 32'h00000000;
      next_ts = ts + 41'h00000000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= 32'h00000000;
      ts <= 41'h00000000000;
    end else begin
      presc <= next_presc;
      ts <= next_ts;
    end
  end

  // ---------------------------------------------------------------
  // Snapshot and stream
  // ---------------------------------------------------------------
  logic [7:0] rec [fault_log_pkg::PRE_BYTES];
  logic [7:0] next_rec [fault_log_pkg::PRE_BYTES];
  st_e st, next_st;
  logic [7:0] idx, next_idx;
  logic [7:0] next_rec_data, next_cyc_pos;
  logic next_rec_valid, next_rec_last, held, next_held;
  logic ctrl_en, cap, adv, done_ev;

  assign cap = fault_event && ctrl_en && st == S_IDLE;
  assign adv = !rec_valid || rec_ready;

  always_comb begin
    int b;
    b = 0;
    next_rec = rec;
    next_held = held || cap;
    if (cap) begin
      next_rec[fault_log_pkg::B_PTR] = log_pointer;
      next_rec[fault_log_pkg::B_VCNT] = valid_count;
      for (int i = 0; i < 5; i++) begin
        next_rec[fault_log_pkg::B_TS + i] = ts[8 * i +: 8];
      end
      next_rec[fault_log_pkg::B_TS_TOP] = {7'h00, ts[40]};
      for (int c = 0; c < 8; c++) begin
        b = ext_base(c);
        next_rec[b] = vout_peak[c][7:0];
        next_rec[b + 1] = vout_peak[c][15:8];
        next_rec[b + 2] = vout_min[c][7:0];
        next_rec[b + 3] = vout_min[c][15:8];
        b = fault_log_pkg::B_STAT + 3 * c;
        next_rec[b] = vout_status[c];
        next_rec[b + 1] = vendor_status[c];
        next_rec[b + 2] = vendor_status2[c];
      end
      b = fault_log_pkg::B_VIN;
      next_rec[b] = vin_peak[7:0];
      next_rec[b + 1] = vin_peak[15:8];
      next_rec[b + 2] = vin_min[7:0];
      next_rec[b + 3] = vin_min[15:8];
      b = fault_log_pkg::B_TEMP;
      next_rec[b] = temp_peak[7:0];
      next_rec[b + 1] = temp_peak[15:8];
      next_rec[b + 2] = temp_min[7:0];
      next_rec[b + 3] = temp_min[15:8];
    end
  end

  always_comb begin
    next_st = st;
    next_idx = idx;
    next_rec_valid = rec_valid;
    next_rec_data = rec_data;
    next_rec_last = rec_last;
    next_cyc_pos = cyc_pos;
    done_ev = 1'b0;
    unique case (st)
      S_IDLE: begin
        if (read_start) begin
          next_rec_valid = 1'b1;
          next_rec_data = fault_log_pkg::BLK_COUNT;
          next_idx = 8'h00;
          next_st = S_PRE;
        end
      end
      S_PRE: begin
        if (adv) begin
          next_rec_data = rec[idx[6:0]];
          next_idx = idx + 8'h01;
          if (idx == 8'(fault_log_pkg::B_PRE_END)) begin
            next_cyc_pos = rec[fault_log_pkg::B_PTR];
            next_st = S_CYC;
          end
        end
      end
      S_CYC: begin
        if (adv) begin
          next_rec_data = cyc_byte;
          next_idx = idx + 8'h01;
          next_cyc_pos = (cyc_pos == 8'h00) ?
            8'(fault_log_pkg::LOOP_BYTES - 1) : cyc_pos - 8'h01;
          if (idx == 8'(fault_log_pkg::REC_END)) begin
            next_rec_last = 1'b1;
            next_st = S_LAST;
          end
        end
      end
      S_LAST: begin
        if (rec_ready) begin
          next_rec_valid = 1'b0;
          next_rec_last = 1'b0;
          done_ev = 1'b1;
          next_st = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      idx <= 8'h00;
      rec_valid <= 1'b0;
      rec_data <= 8'h00;
      rec_last <= 1'b0;
      cyc_pos <= 8'h00;
      held <= 1'b0;
      for (int i = 0; i < fault_log_pkg::PRE_BYTES; i++) begin
        rec[i] <= 8'h00;
      end
    end else begin
      st <= next_st;
      idx <= next_idx;
      rec_valid <= next_rec_valid;
      rec_data <= next_rec_data;
      rec_last <= next_rec_last;
      cyc_pos <= next_cyc_pos;
      held <= next_held;
      rec <= next_rec;
    end
  end

  // ---------------------------------------------------------------
  // Register slave and interrupt
  // ---------------------------------------------------------------
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic w_b0, next_w_b0, next_ctrl_en;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid, next_irq;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [1:0] int_stat, int_en, next_int_stat, next_int_en, clr;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_b0 = w_b0;
    next_ctrl_en = ctrl_en;
    next_int_en = int_en;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    clr = 2'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_b0 = s_axi_wstrb[0];
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = fault_log_pkg::RESP_OKAY;
      unique case (aw_addr)
        fault_log_pkg::A_CTRL: begin
          if (w_b0) next_ctrl_en = w_data[0];
        end
        fault_log_pkg::A_INT_CLR: begin
          if (w_b0) clr = w_data[1:0];
        end
        fault_log_pkg::A_INT_EN: begin
          if (w_b0) next_int_en = w_data[1:0];
        end
        fault_log_pkg::A_STATUS, fault_log_pkg::A_INT_STAT,
        fault_log_pkg::A_TS_LO, fault_log_pkg::A_TS_HI: begin
        end
        default: next_bresp = fault_log_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = fault_log_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fault_log_pkg::A_CTRL: next_rdata = {31'h0, ctrl_en};
        fault_log_pkg::A_STATUS:
          next_rdata = {30'h0, st != S_IDLE, held};
        fault_log_pkg::A_INT_STAT: next_rdata = {30'h0, int_stat};
        fault_log_pkg::A_INT_CLR: next_rdata = 32'h00000000;
        fault_log_pkg::A_INT_EN: next_rdata = {30'h0, int_en};
        fault_log_pkg::A_TS_LO: next_rdata = ts[31:0];
        fault_log_pkg::A_TS_HI: next_rdata = {23'h0, ts[40:32]};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = fault_log_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_hold;
    next_wready = !next_w_hold;
    next_arready = !next_rvalid;
    // Hardware set wins over a same-cycle clear
    next_int_stat = (int_stat & ~clr) | {done_ev, cap};
    next_irq = |(next_int_stat & next_int_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_b0 <= 1'b0;
      ctrl_en <= fault_log_pkg::CTRL_RST;
      int_en <= fault_log_pkg::INT_EN_RST;
      int_stat <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      irq <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_b0 <= next_w_b0;
      ctrl_en <= next_ctrl_en;
      int_en <= next_int_en;
      int_stat <= next_int_stat;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence start_s;
    st == S_IDLE && read_start;
  endsequence
  sequence count_taken_s;
    st == S_PRE && idx == 8'h00 && rec_valid && rec_ready;
  endsequence
  sequence pre_end_s;
    st == S_PRE && adv && idx == 8'h47;
  endsequence

  ptr_capture_a: assert property (cap |=> rec[0] == $past(log_pointer))
    else $error("pointer byte not captured");
  vcnt_capture_a: assert property (cap |=> rec[1] == $past(valid_count))
    else $error("valid count byte not captured");
  ts_bytes_a: assert property (cap |=>
    {rec[7], rec[6], rec[5], rec[4], rec[3], rec[2]} == {7'h00, $past(ts)})
    else $error("timestamp bytes misplaced");
  ts_tick_a: assert property ($changed(ts) |->
    $past(presc) == 32'(TICK_CYCLES - 1) && ts == $past(ts) + 41'h1)
    else $error("timestamp stepped at wrong time");
  ch_extremes_a: assert property (cap |=>
    {rec[9], rec[8], rec[11], rec[10]} == {$past(vout_peak[0]),
    $past(vout_min[0])} && {rec[47], rec[46]} == $past(vout_min[7]))
    else $error("channel extremes misplaced");
  vin_place_a: assert property (cap |=>
    {rec[17], rec[16], rec[19], rec[18]} == {$past(vin_peak), $past(vin_min)})
    else $error("input supply extremes misplaced");
  temp_place_a: assert property (cap |=> {rec[29], rec[28], rec[31],
    rec[30]} == {$past(temp_peak), $past(temp_min)})
    else $error("temperature extremes misplaced");
  status_place_a: assert property (cap |=>
    {rec[48], rec[49], rec[50], rec[71]} == {$past(vout_status[0]),
    $past(vendor_status[0]), $past(vendor_status2[0]),
    $past(vendor_status2[7])})
    else $error("status bytes misplaced");
  pre_end_a: assert property (pre_end_s |=>
    rec_data == rec[71] && st == S_CYC && cyc_pos == rec[0])
    else $error("preamble did not end at byte 71");
  loop_walk_a: assert property (st == S_CYC && adv && idx != 8'hED |=>
    cyc_pos == ($past(cyc_pos) == 8'h00 ? 8'h2D : $past(cyc_pos) - 8'h01))
    else $error("cyclic position walk wrong");
  count_first_a: assert property (start_s |=>
    rec_valid && rec_data == fault_log_pkg::BLK_COUNT)
    else $error("count byte not first");
  ptr_second_a: assert property (count_taken_s |=>
    rec_valid && rec_data == rec[fault_log_pkg::B_PTR])
    else $error("pointer byte not right after count");
  snap_hold_a: assert property (st != S_IDLE |=> $stable(rec[0]) &&
    $stable(rec[7]) && $stable(rec[71]))
    else $error("snapshot changed while streaming");
endmodule

// *** test/log_reader_model.sv ***
// Far-side model: record sink that stalls, plus cyclic log storage.
// Assumes the formatter's stream ports, all on the aclk domain.
`timescale 1ns/1ps
module log_reader_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Record stream
  input wire logic rec_valid,
  input wire logic [7:0] rec_data,
  input wire logic rec_last,
  output logic rec_ready,
  // Cyclic storage
  input wire logic [7:0] cyc_pos,
  output logic [7:0] cyc_byte
);
  logic [7:0] got [0:255];
  int count;
  int last_at;
  logic [1:0] phase;
  // Storage answers in the same cycle, one value per loop position
  assign cyc_byte = 8'h5A ^ cyc_pos;
  // Sink refuses one cycle in three
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 0;
      last_at <= -1;
      phase <= 2'h0;
      rec_ready <= 1'b0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      rec_ready <= (phase != 2'h1);
      if (rec_valid && rec_ready) begin
        got[count] <= rec_data;
        count <= count + 1;
        if (rec_last)
          last_at <= count;
      end
    end
  end
endmodule

// *** test/test_fault_log_preamble_formatter.sv ***
// Self-checking bench for the fault-log preamble formatter.
// Assumes log_reader_model as the stream sink and cyclic storage.
`timescale 1ns/1ps
module test_fault_log_preamble_formatter;
  localparam int TICK = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, rec_valid, rec_last, rec_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] rec_data, cyc_pos, cyc_byte;
  logic fault_event = 1'b0, read_start = 1'b0;
  logic [7:0] log_pointer = 8'h00, valid_count = 8'h00;
  logic [7:0][15:0] vout_peak = '0, vout_min = '0;
  logic [15:0] vin_peak = 16'h0, vin_min = 16'h0;
  logic [15:0] temp_peak = 16'h0, temp_min = 16'h0;
  logic [7:0][7:0] vout_status = '0, vendor_status = '0, vendor_status2 = '0;
  logic [7:0] exp_rec [0:71];
  int fails = 0;
  int checks_done = 0;

  fault_log_preamble_formatter #(.TICK_CYCLES(TICK)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .fault_event, .log_pointer, .valid_count,
    .vout_peak, .vout_min, .vin_peak, .vin_min, .temp_peak, .temp_min,
    .vout_status, .vendor_status, .vendor_status2, .read_start,
    .rec_valid, .rec_data, .rec_last, .rec_ready, .cyc_pos, .cyc_byte);

  log_reader_model i_host (
    .aclk, .aresetn, .rec_valid, .rec_data, .rec_last, .rec_ready,
    .cyc_pos, .cyc_byte);

  always #2 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hang;
    fails++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] want);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (n == 100)
      hang();
    chk(32'(s_axi_bresp), 32'(want));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (n == 100)
      hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task set_snapshot(input logic [7:0] b, input logic [7:0] p);
    int c;
    @(posedge aclk);
    for (c = 0; c < 8; c++) begin
      vout_peak[c] <= {b, 8'h10 + 8'(c)};
      vout_min[c] <= {b, 8'h20 + 8'(c)};
      vout_status[c] <= b ^ (8'h40 + 8'(c));
      vendor_status[c] <= b ^ (8'h50 + 8'(c));
      vendor_status2[c] <= b ^ (8'h60 + 8'(c));
    end
    vin_peak <= {b, 8'h30};
    vin_min <= {b, 8'h31};
    temp_peak <= {b, 8'h32};
    temp_min <= {b, 8'h33};
    log_pointer <= p;
    valid_count <= b;
  endtask

  task build_exp(input logic [7:0] b, input logic [7:0] p);
    int c;
    int k;
    exp_rec[0] = p;
    exp_rec[1] = b;
    for (c = 0; c < 10; c++) begin
      k = (c < 2) ? 8 + 4 * c : (c < 4) ? 12 + 4 * c : 16 + 4 * c;
      if (c > 7)
        k = (c < 10) ? 16 + 12 * (c - 8) : 28 + 2 * (c - 10);
      exp_rec[k] = (c < 8) ? 8'h10 + 8'(c) : 8'h30 + 8'(2 * (c & 1));
      exp_rec[k + 1] = b;
      exp_rec[k + 2] = (c < 8) ? 8'h20 + 8'(c) : exp_rec[k] + 8'h01;
      exp_rec[k + 3] = b;
      if (c < 8) begin
        exp_rec[48 + 3 * c] = b ^ (8'h40 + 8'(c));
        exp_rec[49 + 3 * c] = b ^ (8'h50 + 8'(c));
        exp_rec[50 + 3 * c] = b ^ (8'h60 + 8'(c));
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic regs_check;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(fault_log_pkg::A_CTRL, d, r);
    chk(d, 32'h1);
    chk(32'(r), 32'(fault_log_pkg::RESP_OKAY));
    axi_rd(fault_log_pkg::A_INT_EN, d, r);
    chk(d, 32'h0);
    axi_rd(fault_log_pkg::A_TS_HI, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(fault_log_pkg::RESP_OKAY));
    axi_rd(8'h1C, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(fault_log_pkg::RESP_SLVERR));
    axi_wr(8'h1C, 32'h1, fault_log_pkg::RESP_SLVERR);
  endtask

  task automatic tick_check;
    logic [31:0] t0, t1;
    logic [1:0] r;
    realtime s;
    int e;
    axi_rd(fault_log_pkg::A_TS_LO, t0, r);
    s = $realtime;
    repeat (40) @(posedge aclk);
    axi_rd(fault_log_pkg::A_TS_LO, t1, r);
    e = int'(($realtime - s) / 4.0) / TICK;
    chk(32'(int'(t1 - t0) >= e - 1 && int'(t1 - t0) <= e + 1), 32'h1);
  endtask

  task automatic stream_check;
    logic [31:0] t0;
    logic [1:0] r;
    logic [40:0] ts;
    int n;
    int k;
    axi_wr(fault_log_pkg::A_INT_EN, 32'h3, fault_log_pkg::RESP_OKAY);
    set_snapshot(8'hA0, 8'd11);
    build_exp(8'hA0, 8'd11);
    axi_rd(fault_log_pkg::A_TS_LO, t0, r);
    @(posedge aclk);
    fault_event <= 1'b1;
    @(posedge aclk);
    fault_event <= 1'b0;
    set_snapshot(8'h3C, 8'd20);
    chk(32'(irq), 32'h1);
    @(posedge aclk);
    read_start <= 1'b1;
    @(posedge aclk);
    read_start <= 1'b0;
    for (n = 0; n < 2000 && i_host.count < 239; n++) begin
      @(posedge aclk);
      fault_event <= (n == 60);
    end
    if (n == 2000)
      hang();
    chk(32'(i_host.got[0]), 32'(fault_log_pkg::BLK_COUNT));
    for (k = 0; k < 72; k++) begin
      if (k < 2 || k > 7)
        chk(32'(i_host.got[k + 1]), 32'(exp_rec[k]));
    end
    ts = {i_host.got[8][0], i_host.got[7], i_host.got[6], i_host.got[5],
          i_host.got[4], i_host.got[3]};
    chk(32'(i_host.got[8][7:1]), 32'h0);
    chk(32'(ts >= 41'(t0) && ts <= 41'(t0) + 41'd3), 32'h1);
    for (k = 0; k < 166; k++)
      chk(32'(i_host.got[73 + k]), 32'(8'h5A ^ 8'((11 - k % 46 + 46) % 46)));
    chk(32'(i_host.last_at), 32'd238);
  endtask

  task automatic irq_check;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(fault_log_pkg::A_STATUS, d, r);
    chk(d, 32'h1);
    axi_rd(fault_log_pkg::A_INT_STAT, d, r);
    chk(d, 32'h3);
    axi_wr(fault_log_pkg::A_INT_EN, 32'h0, fault_log_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    axi_wr(fault_log_pkg::A_INT_EN, 32'h3, fault_log_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    // Lane 0 strobe low: write must be ignored
    s_axi_wstrb <= 4'hE;
    axi_wr(fault_log_pkg::A_INT_EN, 32'h0, fault_log_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(fault_log_pkg::A_INT_EN, d, r);
    chk(d, 32'h3);
    axi_wr(fault_log_pkg::A_INT_CLR, 32'h3, fault_log_pkg::RESP_OKAY);
    axi_rd(fault_log_pkg::A_INT_STAT, d, r);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    axi_wr(fault_log_pkg::A_CTRL, 32'h0, fault_log_pkg::RESP_OKAY);
    @(posedge aclk);
    fault_event <= 1'b1;
    @(posedge aclk);
    fault_event <= 1'b0;
    axi_rd(fault_log_pkg::A_INT_STAT, d, r);
    chk(d, 32'h0);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    regs_check();
    tick_check();
    stream_check();
    irq_check();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end
endmodule
